// file: rtl/mmso_params.svh
`ifndef MMSO_PARAMS_SVH
`define MMSO_PARAMS_SVH
// ============================================================
// Opcode patterns
`define MMSO_OPC_LOADLIT   8'h0e
`define MMSO_OPC_MULLIT    8'h0d
`define MMSO_OPC_MULFILE   7'h01
`define MMSO_OPC_NEG       7'h36
`define MMSO_OPC_STORE     7'h37
`define MMSO_OPC_CALL      5'h1b
`define MMSO_OPC_NOPF      4'hf
`define MMSO_WORD_NOP      16'h0000
`define MMSO_WORD_PUSH     16'h0005
`define MMSO_WORD_POP      16'h0006
// ============================================================
// Operand fields
`define MMSO_BANKSEL_BIT   8
`define MMSO_IDX_LIMIT     8'h5f
`define MMSO_ACC_LO_BANK   6'h00
`define MMSO_ACC_HI_BANK   6'h3f
`define MMSO_PC_STEP       2
// ============================================================
// Register byte offsets
`define MMSO_REG_CTRL      12'h000
`define MMSO_REG_ACC       12'h004
`define MMSO_REG_BANK      12'h008
`define MMSO_REG_PROD      12'h00c
`define MMSO_REG_STATUS    12'h010
`define MMSO_REG_PC        12'h014
`define MMSO_REG_STKHEAD   12'h018
`define MMSO_REG_STKINFO   12'h01c
`define MMSO_REG_IDXBASE   12'h020
// ============================================================
// Field positions and reset values
`define MMSO_CTRL_EXT_BIT  0
`define MMSO_CTRL_RUN_BIT  1
`define MMSO_CTRL_RESET    2'h2
`define MMSO_ST_C_BIT      0
`define MMSO_ST_DC_BIT     1
`define MMSO_ST_Z_BIT      2
`define MMSO_ST_OV_BIT     3
`define MMSO_ST_N_BIT      4
`define MMSO_STK_OVF_BIT   8
`define MMSO_STK_UNF_BIT   9
`define MMSO_OVF_MIN       8'h80
`endif

// file: rtl/mmso_pkg.sv
`default_nettype none
package mmso_pkg;
    // ============================================================
    // Quarter phases of one instruction cycle.
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } mmso_phase_t;

    // ============================================================
    // Decoded operations.
    typedef enum logic [3:0] {
        OP_IDLE    = 4'h0,
        OP_LOADLIT = 4'h1,
        OP_STORE   = 4'h2,
        OP_MULLIT  = 4'h3,
        OP_MULFILE = 4'h4,
        OP_NEG     = 4'h5,
        OP_POP     = 4'h6,
        OP_PUSH    = 4'h7,
        OP_CALL    = 4'h8,
        OP_UNSUP   = 4'h9
    } mmso_op_t;

    // ============================================================
    // Register bus and file port carriers.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } mmso_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } mmso_apb_rsp_t;

    typedef struct packed {
        logic        re;
        logic        we;
        logic [13:0] addr;
        logic [7:0]  wdata;
    } mmso_file_req_t;
endpackage
`default_nettype wire

// file: rtl/mmso_core.sv
// Added by the designer: the APB register port and the address map.
`include "mmso_params.svh"
`timescale 1ns/100ps
`default_nettype none
module mmso_core #(
    parameter int STACK_DEPTH = 31,
    parameter int PC_W        = 21
) (
    input  wire logic                  I_SYS_CLK,
    input  wire logic                  I_SRST,
    input  wire logic                  I_CE,
    input  wire mmso_pkg::mmso_apb_req_t I_APB,
    output mmso_pkg::mmso_apb_rsp_t    O_APB,
    input  wire logic                  I_INSTR_VALID,
    input  wire logic [15:0]           I_INSTR,
    output logic                       O_INSTR_READY,
    output logic [PC_W-1:0]            O_PC,
    output mmso_pkg::mmso_file_req_t   O_FILE,
    input  wire logic [7:0]            I_FILE_RDATA
);
    import mmso_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH + 1);

    // ============================================================
    // Decode helpers
    function automatic mmso_op_t decode_op(input logic [15:0] w);
        mmso_op_t op;
        op = OP_UNSUP;
        if (w == `MMSO_WORD_NOP || w[15:12] == `MMSO_OPC_NOPF) begin
            op = OP_IDLE;
        end else if (w[15:8] == `MMSO_OPC_LOADLIT) begin
            op = OP_LOADLIT;
        end else if (w[15:8] == `MMSO_OPC_MULLIT) begin
            op = OP_MULLIT;
        end else if (w[15:9] == `MMSO_OPC_MULFILE) begin
            op = OP_MULFILE;
        end else if (w[15:9] == `MMSO_OPC_NEG) begin
            op = OP_NEG;
        end else if (w[15:9] == `MMSO_OPC_STORE) begin
            op = OP_STORE;
        end else if (w == `MMSO_WORD_POP) begin
            op = OP_POP;
        end else if (w == `MMSO_WORD_PUSH) begin
            op = OP_PUSH;
        end else if (w[15:11] == `MMSO_OPC_CALL) begin
            op = OP_CALL;
        end
        return op;
    endfunction

    // The operand address is formed once, at decode, so the file port
    // sees a stable address through the whole read and write.
    function automatic logic [13:0] file_addr(input logic [15:0] w,
                                              input logic [5:0]  bank,
                                              input logic        ext,
                                              input logic [13:0] base);
        logic [13:0] a;
        a = {bank, w[7:0]};
        if (!w[`MMSO_BANKSEL_BIT]) begin
            if (ext && w[7:0] <= `MMSO_IDX_LIMIT) begin
                a = base + {6'h00, w[7:0]};
            end else if (w[7:0] <= `MMSO_IDX_LIMIT) begin
                a = {`MMSO_ACC_LO_BANK, w[7:0]};
            end else begin
                a = {`MMSO_ACC_HI_BANK, w[7:0]};
            end
        end
        return a;
    endfunction

    // ============================================================
    // State
    mmso_phase_t        ph_q;
    mmso_op_t           op_q;
    logic [15:0]        instr_q;
    logic               word_q;
    logic [7:0]         acc_q;
    logic [5:0]         bank_q;
    logic [13:0]        base_q;
    logic [15:0]        prod_q;
    logic [4:0]         flags_q;
    logic [7:0]         opnd_q;
    logic               ext_q;
    logic               run_q;
    logic [PC_W-1:0]    stk_q [STACK_DEPTH];
    logic [SP_W-1:0]    sp_q;
    logic               ovf_q;
    logic               unf_q;

    logic               step;
    logic               take;
    logic               commit;
    logic               apb_wr;
    logic               apb_acc;
    logic [PC_W-1:0]    pc_next;
    logic [PC_W-1:0]    call_tgt;
    logic [PC_W-1:0]    head;
    logic               full;
    logic               empty;
    logic               push_ok;
    logic               pop_ok;
    logic [7:0]         neg_res;
    logic [31:0]        rd_data;
    logic               rd_ok;
    logic               ovf_clr;
    logic               unf_clr;

    assign step    = I_CE && run_q;
    assign take    = step && ph_q == PH_Q1 && O_INSTR_READY && I_INSTR_VALID;
    assign commit  = step && ph_q == PH_Q4;
    assign apb_acc = I_APB.psel && I_APB.penable && O_APB.pready;
    assign apb_wr  = I_CE && apb_acc && I_APB.pwrite && rd_ok;
    assign pc_next = O_PC + PC_W'(`MMSO_PC_STEP);
    assign call_tgt = pc_next + {{(PC_W-12){instr_q[10]}},
                                 instr_q[10:0], 1'b0};
    assign full    = sp_q == SP_W'(STACK_DEPTH);
    assign empty   = sp_q == '0;
    assign head    = empty ? '0 : stk_q[sp_q - 1'b1];
    assign push_ok = commit && (op_q == OP_PUSH || op_q == OP_CALL) && !full;
    assign pop_ok  = commit && op_q == OP_POP && !empty;
    assign neg_res = 8'(~opnd_q + 8'h01);
    assign ovf_clr = apb_wr && I_APB.paddr == `MMSO_REG_STKINFO
                     && I_APB.pwdata[`MMSO_STK_OVF_BIT];
    assign unf_clr = apb_wr && I_APB.paddr == `MMSO_REG_STKINFO
                     && I_APB.pwdata[`MMSO_STK_UNF_BIT];

    // ============================================================
    // Quarter phase sequencing
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            ph_q <= PH_Q1;
        end else if (step) begin
            case (ph_q)
                PH_Q1:   ph_q <= PH_Q2;
                PH_Q2:   ph_q <= PH_Q3;
                PH_Q3:   ph_q <= PH_Q4;
                PH_Q4:   ph_q <= PH_Q1;
                default: ph_q <= PH_Q1;
            endcase
        end
    end

    // A word is only taken in Q1; the cycle after a call takes none.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            instr_q       <= `MMSO_WORD_NOP;
            op_q          <= OP_IDLE;
            word_q        <= 1'b0;
            O_INSTR_READY <= 1'b1;
        end else if (step) begin
            if (ph_q == PH_Q1) begin
                instr_q       <= take ? I_INSTR : `MMSO_WORD_NOP;
                op_q          <= take ? decode_op(I_INSTR) : OP_IDLE;
                word_q        <= take;
                O_INSTR_READY <= 1'b0;
            end
            if (ph_q == PH_Q4) begin
                O_INSTR_READY <= op_q != OP_CALL;
            end
        end
    end

    // ============================================================
    // File register port
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_FILE <= '0;
        end else if (step) begin
            case (ph_q)
                PH_Q1: begin
                    O_FILE.addr <= file_addr(I_INSTR, bank_q, ext_q, base_q);
                    O_FILE.re   <= take && (decode_op(I_INSTR) == OP_MULFILE
                                   || decode_op(I_INSTR) == OP_NEG);
                end
                PH_Q2: O_FILE.re <= 1'b0;
                PH_Q3: begin
                    O_FILE.we    <= op_q == OP_STORE || op_q == OP_NEG;
                    O_FILE.wdata <= op_q == OP_NEG ? 8'(~I_FILE_RDATA + 8'h01)
                                    : acc_q;
                end
                PH_Q4:   O_FILE.we <= 1'b0;
                default: O_FILE.we <= 1'b0;
            endcase
        end
    end

    // Read data is sampled at the end of Q3, a cycle after the strobe.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            opnd_q <= 8'h00;
        end else if (step && ph_q == PH_Q3) begin
            opnd_q <= I_FILE_RDATA;
        end
    end

    // ============================================================
    // Accumulator, product and flags
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            acc_q <= 8'h00;
        end else if (commit && op_q == OP_LOADLIT) begin
            acc_q <= instr_q[7:0];
        end else if (apb_wr && I_APB.paddr == `MMSO_REG_ACC) begin
            acc_q <= I_APB.pwdata[7:0];
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            prod_q <= 16'h0000;
        end else if (commit && op_q == OP_MULLIT) begin
            prod_q <= 16'(acc_q) * 16'(instr_q[7:0]);
        end else if (commit && op_q == OP_MULFILE) begin
            prod_q <= 16'(acc_q) * 16'(opnd_q);
        end
    end

    // Only negate reaches the flags; multiplies never do.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            flags_q <= 5'h00;
        end else if (commit && op_q == OP_NEG) begin
            flags_q[`MMSO_ST_N_BIT]  <= neg_res[7];
            flags_q[`MMSO_ST_Z_BIT]  <= neg_res == 8'h00;
            flags_q[`MMSO_ST_C_BIT]  <= opnd_q == 8'h00;
            flags_q[`MMSO_ST_DC_BIT] <= opnd_q[3:0] == 4'h0;
            flags_q[`MMSO_ST_OV_BIT] <= opnd_q == `MMSO_OVF_MIN;
        end
    end

    // ============================================================
    // Program counter
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_PC <= '0;
        end else if (commit && op_q == OP_CALL) begin
            O_PC <= call_tgt;
        end else if (commit && word_q) begin
            // Any taken word steps, the idle encodings too; a cycle with
            // no word taken leaves the counter free for a bus write.
            O_PC <= pc_next;
        end else if (apb_wr && I_APB.paddr == `MMSO_REG_PC) begin
            O_PC <= {I_APB.pwdata[PC_W-1:1], 1'b0};
        end
    end

    // ============================================================
    // Return stack
    // A full stack drops the push and an empty one ignores the pop;
    // each sets a sticky flag so software can see the lost entry.
    always_ff @(posedge I_SYS_CLK) begin
        if (push_ok) begin
            stk_q[sp_q] <= pc_next;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            sp_q <= '0;
        end else if (push_ok) begin
            sp_q <= sp_q + 1'b1;
        end else if (pop_ok) begin
            sp_q <= sp_q - 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            if (commit && (op_q == OP_PUSH || op_q == OP_CALL) && full) begin
                ovf_q <= 1'b1;
            end else if (ovf_clr) begin
                ovf_q <= 1'b0;
            end
            if (commit && op_q == OP_POP && empty) begin
                unf_q <= 1'b1;
            end else if (unf_clr) begin
                unf_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // Control registers
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            {run_q, ext_q} <= `MMSO_CTRL_RESET;
            bank_q         <= 6'h00;
            base_q         <= 14'h0000;
        end else if (apb_wr) begin
            if (I_APB.paddr == `MMSO_REG_CTRL) begin
                ext_q <= I_APB.pwdata[`MMSO_CTRL_EXT_BIT];
                run_q <= I_APB.pwdata[`MMSO_CTRL_RUN_BIT];
            end
            if (I_APB.paddr == `MMSO_REG_BANK) begin
                bank_q <= I_APB.pwdata[5:0];
            end
            if (I_APB.paddr == `MMSO_REG_IDXBASE) begin
                base_q <= I_APB.pwdata[13:0];
            end
        end
    end

    // ============================================================
    // Register bus
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        case (I_APB.paddr)
            `MMSO_REG_CTRL:    rd_data = {30'h0, run_q, ext_q};
            `MMSO_REG_ACC:     rd_data = {24'h0, acc_q};
            `MMSO_REG_BANK:    rd_data = {26'h0, bank_q};
            `MMSO_REG_PROD:    rd_data = {16'h0, prod_q};
            `MMSO_REG_STATUS:  rd_data = {27'h0, flags_q};
            `MMSO_REG_PC:      rd_data = 32'(O_PC);
            `MMSO_REG_STKHEAD: rd_data = 32'(head);
            `MMSO_REG_STKINFO: rd_data = {22'h0, unf_q, ovf_q, 8'(sp_q)};
            `MMSO_REG_IDXBASE: rd_data = {18'h0, base_q};
            default:           rd_ok   = 1'b0;
        endcase
    end

    // Ready comes one cycle into the access phase, so data is registered.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_APB <= '0;
        end else if (I_CE) begin
            O_APB.pready <= I_APB.psel && I_APB.penable && !O_APB.pready;
            if (I_APB.psel && I_APB.penable && !O_APB.pready) begin
                O_APB.prdata  <= I_APB.pwrite ? 32'h0 : rd_data;
                O_APB.pslverr <= !rd_ok;
            end else begin
                O_APB.prdata  <= 32'h0;
                O_APB.pslverr <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/mmso_core_monitor.sv
`include "mmso_params.svh"
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Port checker for the decode core; the timing checks assume the clock enable stays high.
module mmso_core_monitor #(
    parameter int STACK_DEPTH = 31,
    parameter int PC_W        = 21
) (
    input wire logic                     I_SYS_CLK,
    input wire logic                     I_SRST,
    input wire logic                     I_CE,
    input wire mmso_pkg::mmso_apb_req_t  I_APB,
    input wire mmso_pkg::mmso_apb_rsp_t  O_APB,
    input wire logic                     I_INSTR_VALID,
    input wire logic [15:0]              I_INSTR,
    input wire logic                     O_INSTR_READY,
    input wire logic [PC_W-1:0]          O_PC,
    input wire mmso_pkg::mmso_file_req_t O_FILE,
    input wire logic [7:0]               I_FILE_RDATA
);
    import mmso_pkg::*;
    logic            take;
    logic            is_call;
    logic [PC_W-1:0] call_tgt;
    assign take = I_INSTR_VALID && O_INSTR_READY && I_CE;
    assign is_call = I_INSTR[15:11] == `MMSO_OPC_CALL;
    assign call_tgt = O_PC + PC_W'(2)
        + {{(PC_W-11){I_INSTR[10]}}, I_INSTR[9:0], 1'b0};
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SRST);
    ready_gap_a: assert property (
        take && !is_call |=> !O_INSTR_READY [*3] ##1 O_INSTR_READY)
        else $error("ready gap wrong after single-cycle word");
    call_gap_a: assert property (
        take && is_call |=> !O_INSTR_READY [*7] ##1 O_INSTR_READY)
        else $error("call did not take two cycles");
    call_target_a: assert property (
        take && is_call |-> ##4 O_PC == $past(call_tgt, 4))
        else $error("call target wrong");
    pc_step_a: assert property (
        take && !is_call |-> ##4 O_PC == $past(O_PC, 4) + PC_W'(2))
        else $error("program counter did not step by one word");
    store_write_a: assert property (
        take && I_INSTR[15:9] == `MMSO_OPC_STORE
        |-> ##3 O_FILE.we ##1 !O_FILE.we)
        else $error("store write strobe misplaced");
    neg_value_a: assert property (
        take && I_INSTR[15:9] == `MMSO_OPC_NEG |-> ##3 O_FILE.we
        && O_FILE.wdata == 8'h00 - $past(I_FILE_RDATA))
        else $error("negate wrote wrong value");
    mul_read_a: assert property (
        take && I_INSTR[15:9] == `MMSO_OPC_MULFILE
        |=> (O_FILE.re && !O_FILE.we) ##1 (!O_FILE.re && !O_FILE.we) [*2])
        else $error("multiply file access wrong");
    addr_field_a: assert property (
        take && I_INSTR[15:10] == 6'h1b && I_INSTR[8]
        |=> O_FILE.addr[7:0] == $past(I_INSTR[7:0]))
        else $error("file address byte wrong");
    nop_quiet_a: assert property (
        take && (I_INSTR == `MMSO_WORD_NOP
        || I_INSTR[15:12] == `MMSO_OPC_NOPF)
        |=> (!O_FILE.re && !O_FILE.we) [*3])
        else $error("idle word touched the file");
endmodule
bind mmso_core mmso_core_monitor #(
    .STACK_DEPTH(STACK_DEPTH),
    .PC_W       (PC_W)
) mmso_core_monitor_inst (
    .I_SYS_CLK, .I_SRST, .I_CE, .I_APB, .O_APB, .I_INSTR_VALID,
    .I_INSTR, .O_INSTR_READY, .O_PC, .O_FILE, .I_FILE_RDATA
);
`default_nettype wire

// file: tb/move_multiply_stack_ops_tb.sv
`include "mmso_params.svh"
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Bench for the decode core.
module move_multiply_stack_ops_tb;
    import mmso_pkg::*;
    localparam int PW = 21;
    logic           clk;
    logic           srst;
    logic           ce;
    mmso_apb_req_t  apb_q;
    mmso_apb_rsp_t  apb_r;
    logic           valid;
    logic           rdy;
    logic [15:0]    instr;
    logic [PW-1:0]  pc;
    mmso_file_req_t fr;
    logic [7:0]     rdata = 8'h00;
    logic [7:0]     fmem [0:16383];
    logic [31:0]    q;
    logic [31:0]    err;
    logic [31:0]    p;
    int             mismatches = 0;
    int             tests_run = 0;
    int             cycles = 0;
    logic [23:0]    neg_tab [3] = '{24'h000007, 24'h80801a, 24'h3ac610};
    logic [31:0]    st_tab [5] = '{32'h6e300030, 32'h6e803f80,
        32'h6fff02ff, 32'h6e5f105f, 32'h6e603f60};
    logic [10:0]    cl_tab [3] = '{11'h7fd, 11'h3ff, 11'h400};

    mmso_core #(.PC_W(PW)) mmso_core_inst (
        .I_SYS_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_APB(apb_q),
        .O_APB(apb_r), .I_INSTR_VALID(valid), .I_INSTR(instr),
        .O_INSTR_READY(rdy), .O_PC(pc), .O_FILE(fr), .I_FILE_RDATA(rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ============================================================
    // File memory. Idle read data shows the inverse of the last
    // value, so a late or missing read cannot pass by chance.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (fr.we) fmem[fr.addr] <= fr.wdata;
        rdata <= fr.re ? fmem[fr.addr] : ~rdata;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ============================================================
    // Access tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        tests_run++;
        if (seen !== e) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, e);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        apb_q <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apb_q.penable <= 1'b1;
        do @(posedge clk); while (apb_r.pready !== 1'b1);
        q = apb_r.prdata;
        err = 32'(apb_r.pslverr);
        apb_q <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(q, e);
    endtask

    task automatic run(input logic [15:0] w);
        valid <= 1'b1;
        instr <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence.
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        valid = 1'b0;
        instr = 16'h0;
        apb_q = '0;
        for (int i = 0; i < 16384; i++) fmem[i] = 8'h00;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(`MMSO_REG_CTRL, 32'h2);
        rd(`MMSO_REG_STKINFO, 32'h0);
        apb(1'b1, 12'h024, 32'h1);
        check(err, 32'h1);
        apb(1'b1, `MMSO_REG_PROD, 32'hffff);
        rd(`MMSO_REG_PROD, 32'h0);
        apb(1'b1, `MMSO_REG_BANK, 32'h2);
        foreach (neg_tab[i]) begin
            fmem[14'h0210] = neg_tab[i][23:16];
            run(16'h6d10);
            rd(`MMSO_REG_STATUS, 32'(neg_tab[i][7:0]));
            check(32'(fmem[14'h0210]), 32'(neg_tab[i][15:8]));
        end
        run(16'h0ee2);
        rd(`MMSO_REG_ACC, 32'he2);
        rd(`MMSO_REG_STATUS, 32'h10);
        run(16'h0dc4);
        rd(`MMSO_REG_PROD, 32'had08);
        rd(`MMSO_REG_ACC, 32'he2);
        run(16'h0ec4);
        fmem[14'h0220] = 8'hb5;
        run(16'h0320);
        rd(`MMSO_REG_PROD, 32'h8a94);
        rd(`MMSO_REG_ACC, 32'hc4);
        check(32'(fmem[14'h0220]), 32'hb5);
        run(16'h0d00);
        rd(`MMSO_REG_PROD, 32'h0);
        rd(`MMSO_REG_STATUS, 32'h10);
        apb(1'b1, `MMSO_REG_IDXBASE, 32'h1000);
        foreach (st_tab[i]) begin
            if (i == 3) apb(1'b1, `MMSO_REG_CTRL, 32'h3);
            run(st_tab[i][31:16]);
            rd(`MMSO_REG_ACC, 32'hc4);
            check(32'(fmem[st_tab[i][13:0]]), 32'hc4);
        end
        apb(1'b0, `MMSO_REG_PC, 32'h0);
        p = q;
        run(16'h0005);
        run(16'h0005);
        rd(`MMSO_REG_STKHEAD, p + 32'h4);
        rd(`MMSO_REG_STKINFO, 32'h2);
        run(16'h0006);
        rd(`MMSO_REG_STKHEAD, p + 32'h2);
        run(16'h0006);
        run(16'h0006);
        rd(`MMSO_REG_STKHEAD, 32'h0);
        rd(`MMSO_REG_STKINFO, 32'h200);
        apb(1'b1, `MMSO_REG_STKINFO, 32'h200);
        rd(`MMSO_REG_STKINFO, 32'h0);
        foreach (cl_tab[i]) begin
            apb(1'b1, `MMSO_REG_PC, 32'h1000);
            run({5'h1b, cl_tab[i]});
            rd(`MMSO_REG_PC,
               32'h1002 + {{20{cl_tab[i][10]}}, cl_tab[i], 1'b0});
            rd(`MMSO_REG_STKHEAD, 32'h1002);
        end
        apb(1'b0, `MMSO_REG_PC, 32'h0);
        p = q;
        run(16'h0000);
        run(16'hf123);
        rd(`MMSO_REG_PC, p + 32'h4);
        rd(`MMSO_REG_STKHEAD, 32'h1002);
        rd(`MMSO_REG_ACC, 32'hc4);
        // A word offered while the clock enable is low must not be taken.
        ce <= 1'b0;
        valid <= 1'b1;
        instr <= 16'h0e55;
        repeat (12) @(posedge clk);
        ce <= 1'b1;
        valid <= 1'b0;
        rd(`MMSO_REG_ACC, 32'hc4);
        rd(`MMSO_REG_PC, p + 32'h4);
        repeat (29) run(16'h0005);
        rd(`MMSO_REG_STKINFO, 32'h11f);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd(`MMSO_REG_STKINFO, 32'h0);
        rd(`MMSO_REG_ACC, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
